// [sdc_divider_chain.sv]
/*
 * sdc_divider_chain: programmable divider chain of a fractional
 * synthesizer: fractional feedback sets a scaled digital VCO, then a
 * high-speed integer and a low-speed power-of-two divider.
 * Assumes the core clock stands for the crystal reference and the VCO is
 * scaled down by 2**(VCO_SHIFT+1) so that its half-periods fit the core clock.
 */
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module sdc_divider_chain
    import sdc_pkg::*;
#(
    parameter int VCO_SHIFT = 11
)
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // register port
    input wire logic [sdc_pkg::SDC_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [sdc_pkg::SDC_DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [sdc_pkg::SDC_DATA_W-1:0] REG_RDATA_O,
    // clocks out
    output logic VCO_TICK_O,
    output logic HS_CLK_O,
    output logic CLK_O
);
    import sdc_pkg::*;

    localparam int ACC_W = SDC_FB_FRAC_W + VCO_SHIFT;

    sdc_div_set_t shadow;
    sdc_div_set_t active;
    logic pending;
    logic [ACC_W-1:0] acc;
    logic half_tick;
    logic hs_clk;
    logic hs_clk_d;
    logic [SDC_LS_CNT_W-1:0] ls_cnt;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_frac = REG_WR_I && (REG_ADDR_I == SDC_OFS_FB_FRAC);
    wire wr_int = REG_WR_I && (REG_ADDR_I == SDC_OFS_FB_INT);
    wire wr_hs = REG_WR_I && (REG_ADDR_I == SDC_OFS_HS);
    wire wr_ls = REG_WR_I && (REG_ADDR_I == SDC_OFS_LS);
    wire wr_ctrl = REG_WR_I && (REG_ADDR_I == SDC_OFS_CTRL);
    wire apply = wr_ctrl && REG_WDATA_I[SDC_CTRL_APPLY_BIT];
    wire shadow_wr = wr_frac || wr_int || wr_hs || wr_ls;

    sdc_div_set_t next_shadow;
    always_comb
    begin
        next_shadow = shadow;
        if (wr_frac)
            next_shadow.feedback_fraction_part = REG_WDATA_I;
        if (wr_int)
            next_shadow.feedback_integer_part = REG_WDATA_I[SDC_FB_INT_W-1:0];
        if (wr_hs)
            next_shadow.high_speed_output_divider = REG_WDATA_I[SDC_HS_W-1:0];
        if (wr_ls)
            next_shadow.low_speed_pow2_divider = REG_WDATA_I[SDC_LS_W-1:0];
    end

    // apply copies the whole shadow set, including a write in the same cycle
    wire sdc_div_set_t next_active = apply ? next_shadow : active;
    // a shadow write leaves the set pending until applied
    wire next_pending = apply ? 1'b0 : (shadow_wr ? 1'b1 : pending);

    wire [SDC_DATA_W-1:0] rd_ctrl = SDC_DATA_W'({pending, 1'b0});
    wire [SDC_DATA_W-1:0] rd_act_div = SDC_DATA_W'({CLK_O,
        5'h00, active.low_speed_pow2_divider, 5'h00, active.high_speed_output_divider});
    wire [SDC_DATA_W-1:0] rd_mux =
        (REG_ADDR_I == SDC_OFS_FB_FRAC) ? shadow.feedback_fraction_part :
        (REG_ADDR_I == SDC_OFS_FB_INT) ? SDC_DATA_W'(shadow.feedback_integer_part) :
        (REG_ADDR_I == SDC_OFS_HS) ? SDC_DATA_W'(shadow.high_speed_output_divider) :
        (REG_ADDR_I == SDC_OFS_LS) ? SDC_DATA_W'(shadow.low_speed_pow2_divider) :
        (REG_ADDR_I == SDC_OFS_CTRL) ? rd_ctrl :
        (REG_ADDR_I == SDC_OFS_ACT_DIV) ? rd_act_div :
        (REG_ADDR_I == SDC_OFS_ACT_INT) ? SDC_DATA_W'(active.feedback_integer_part) :
        (REG_ADDR_I == SDC_OFS_ACT_FRAC) ? active.feedback_fraction_part :
        '0;
    wire [SDC_DATA_W-1:0] next_rdata = REG_RD_I ? rd_mux : '0;

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            shadow <= SDC_DIV_SET_RST;
            active <= SDC_DIV_SET_RST;
            pending <= 1'b0;
            REG_RDATA_O <= '0;
        end
        else
        begin
            shadow <= next_shadow;
            active <= next_active;
            pending <= next_pending;
            REG_RDATA_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // scaled digital VCO: phase accumulator adds the 11.32 value
    // ------------------------------------------------------------
    wire [SDC_FB_W-1:0] fb_value = {active.feedback_integer_part,
        active.feedback_fraction_part};
    wire [ACC_W:0] acc_sum = {1'b0, acc} + (ACC_W+1)'(fb_value);
    wire next_half_tick = acc_sum[ACC_W];

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            acc <= '0;
            half_tick <= 1'b0;
            VCO_TICK_O <= 1'b0;
        end
        else
        begin
            acc <= acc_sum[ACC_W-1:0];
            half_tick <= next_half_tick;
            VCO_TICK_O <= next_half_tick;
        end
    end

    // ------------------------------------------------------------
    // high-speed divider
    // ------------------------------------------------------------
    sdc_hs_div #(
        .HS_W(SDC_HS_W)
    ) u_hs_div (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .half_tick_i(half_tick),
        .ratio_i(active.high_speed_output_divider),
        .clk_o(hs_clk)
    );

    // ------------------------------------------------------------
    // low-speed power-of-two divider
    // ------------------------------------------------------------
    wire [SDC_LS_W-1:0] ls_eff = (active.low_speed_pow2_divider > SDC_LS_MAX) ?
        SDC_LS_MAX : active.low_speed_pow2_divider;
    wire hs_rise = hs_clk && !hs_clk_d;
    wire [SDC_LS_CNT_W-1:0] next_ls_cnt = hs_rise ? ls_cnt + SDC_LS_CNT_W'(1) : ls_cnt;
    wire [SDC_LS_W-1:0] ls_sel = ls_eff - SDC_LS_W'(1);
    // counter bit k toggles every 2**k rising edges: divide by 2**(k+1)
    wire next_clk = (ls_eff == '0) ? hs_clk : next_ls_cnt[ls_sel];

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            hs_clk_d <= 1'b0;
            ls_cnt <= '0;
            HS_CLK_O <= 1'b0;
            CLK_O <= 1'b0;
        end
        else
        begin
            hs_clk_d <= hs_clk;
            ls_cnt <= next_ls_cnt;
            HS_CLK_O <= hs_clk;
            CLK_O <= next_clk;
        end
    end

endmodule

// [sdc_pkg.sv]
/*
 * sdc_pkg: constants, register map and carrier types of the synthesizer
 * divider chain.
 * Assumes a single core clock and a plain address/strobe register port.
 */
package sdc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SDC_ADDR_W = 8;
    localparam int SDC_DATA_W = 32;
    localparam int SDC_FB_INT_W = 11;
    localparam int SDC_FB_FRAC_W = 32;
    localparam int SDC_FB_W = SDC_FB_INT_W + SDC_FB_FRAC_W;
    localparam int SDC_HS_W = 11;
    localparam int SDC_LS_W = 3;
    localparam int SDC_LS_CNT_W = 5;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_FB_FRAC = 8'h00;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_FB_INT = 8'h04;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_HS = 8'h08;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_LS = 8'h0C;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_CTRL = 8'h10;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_ACT_DIV = 8'h14;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_ACT_INT = 8'h18;
    localparam logic [SDC_ADDR_W-1:0] SDC_OFS_ACT_FRAC = 8'h1C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SDC_CTRL_APPLY_BIT = 0;
    localparam int SDC_CTRL_PEND_BIT = 1;
    localparam int SDC_ACT_LS_LSB = 16;
    localparam int SDC_ACT_CLK_BIT = 24;

    // ------------------------------------------------------------
    // reset values: 60.0 feedback, output divide 68 x 1
    // ------------------------------------------------------------
    localparam logic [SDC_FB_INT_W-1:0] SDC_FB_INT_RST = 11'h03C;
    localparam logic [SDC_FB_FRAC_W-1:0] SDC_FB_FRAC_RST = 32'h00000000;
    localparam logic [SDC_HS_W-1:0] SDC_HS_RST = 11'h044;
    localparam logic [SDC_LS_W-1:0] SDC_LS_RST = 3'h0;
    localparam logic [SDC_LS_W-1:0] SDC_LS_MAX = 3'h5;

    // ------------------------------------------------------------
    // carrier: one complete divider setting
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SDC_FB_INT_W-1:0] feedback_integer_part;
        logic [SDC_FB_FRAC_W-1:0] feedback_fraction_part;
        logic [SDC_HS_W-1:0] high_speed_output_divider;
        logic [SDC_LS_W-1:0] low_speed_pow2_divider;
    } sdc_div_set_t;

    localparam sdc_div_set_t SDC_DIV_SET_RST = '{
        feedback_integer_part: SDC_FB_INT_RST,
        feedback_fraction_part: SDC_FB_FRAC_RST,
        high_speed_output_divider: SDC_HS_RST,
        low_speed_pow2_divider: SDC_LS_RST
    };

endpackage

// [sdc_hs_div.sv]
/*
 * sdc_hs_div: high-speed integer divider counting VCO half-periods.
 * Assumes half_tick_i is a one-cycle pulse per VCO half-period.
 */
`timescale 1ns/1ps
module sdc_hs_div
#(
    parameter int HS_W = 11
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control
    input wire logic half_tick_i,
    input wire logic [HS_W-1:0] ratio_i,
    // output
    output logic clk_o
);

    logic [HS_W-1:0] cnt;
    logic [HS_W-1:0] next_cnt;
    logic wrap;

    // ------------------------------------------------------------
    // high for ratio half-periods, low for ratio: 50% even when odd
    // ------------------------------------------------------------
    assign wrap = half_tick_i && (cnt >= ratio_i - HS_W'(1));
    assign next_cnt = wrap ? '0 : (half_tick_i ? cnt + HS_W'(1) : cnt);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt <= '0;
            clk_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            clk_o <= wrap ? !clk_o : clk_o;
        end
    end

endmodule

// [sdc_divider_chain_asserts.sv]
/* sdc_chk: port checks of the divider chain.
   assumes it is bound to sdc_divider_chain. */
`timescale 1ns/1ps
module sdc_chk
(
    // clock, reset, register port, clocks out
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic VCO_TICK_O,
    input wire logic HS_CLK_O,
    input wire logic CLK_O
);
    import sdc_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    property p_rd_quiet;
        !$past(REG_RD_I) |-> REG_RDATA_O == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data off slot");
    property p_unmapped;
        REG_RD_I && REG_ADDR_I > SDC_OFS_ACT_FRAC |=> REG_RDATA_O == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_hs_field;
        REG_WR_I && REG_ADDR_I == SDC_OFS_HS ##1 REG_RD_I && REG_ADDR_I == SDC_OFS_HS
            |=> REG_RDATA_O == {21'h0, $past(REG_WDATA_I[10:0], 2)};
    endproperty
    a_hs_field: assert property (p_hs_field) else $error("hs field");
    property p_ls_field;
        REG_WR_I && REG_ADDR_I == SDC_OFS_LS ##1 REG_RD_I && REG_ADDR_I == SDC_OFS_LS
            |=> REG_RDATA_O == {29'h0, $past(REG_WDATA_I[2:0], 2)};
    endproperty
    a_ls_field: assert property (p_ls_field) else $error("ls field");
    property p_pend_set;
        REG_WR_I && REG_ADDR_I == SDC_OFS_FB_INT ##1 REG_RD_I && REG_ADDR_I == SDC_OFS_CTRL
            |=> REG_RDATA_O[SDC_CTRL_PEND_BIT];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set");
    property p_pend_clr;
        REG_WR_I && REG_ADDR_I == SDC_OFS_CTRL && REG_WDATA_I[SDC_CTRL_APPLY_BIT]
            ##1 REG_RD_I && REG_ADDR_I == SDC_OFS_CTRL |=> !REG_RDATA_O[SDC_CTRL_PEND_BIT];
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
    property p_int_width;
        REG_RD_I && REG_ADDR_I == SDC_OFS_ACT_INT |=> REG_RDATA_O[31:11] == 21'h0;
    endproperty
    a_int_width: assert property (p_int_width) else $error("int width");
    property p_hs_step;
        $changed(HS_CLK_O) |-> $past(VCO_TICK_O, 2);
    endproperty
    a_hs_step: assert property (p_hs_step) else $error("hs edge without tick");
endmodule
bind sdc_divider_chain sdc_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .VCO_TICK_O(VCO_TICK_O),
    .HS_CLK_O(HS_CLK_O), .CLK_O(CLK_O));

// [sdc_host_model.sv]
/* sdc_host: host programming the divider registers.
   assumes each task starts just after a rising edge. */
`timescale 1ns/1ps
module sdc_host
(
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i
);
    import sdc_pkg::*;
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        addr_o <= a;
        wdata_o <= ~wdata_o;
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
        q = rdata_i;
        @(posedge clk_i);
    endtask
    task automatic prog_set(input logic [10:0] fi, input logic [31:0] ff,
                           input logic [10:0] hs, input logic [2:0] ls);
        if (hs >= 11'h005 && hs <= 11'h7FE && (hs <= 11'h021 || !hs[0]))
        begin
            wr(SDC_OFS_FB_FRAC, ff);
            wr(SDC_OFS_FB_INT, {21'h0, fi});
            wr(SDC_OFS_HS, {21'h0, hs});
            wr(SDC_OFS_LS, {29'h0, ls});
            wr(SDC_OFS_CTRL, 32'h1);
        end
        wr_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// [tb.sv]
/* tb: register and clock-path test of the divider chain.
   assumes sdc_host drives the register port. */
`timescale 1ns/1ps
module tb;
    import sdc_pkg::*;
    logic clk;
    logic rstn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] q;
    logic wr;
    logic rd;
    logic tick;
    logic hs_clk;
    logic out_clk;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int per;
    int hi;
    logic [10:0] hs_tab [8] = '{11'h7FE, 11'h005, 11'h007, 11'h006, 11'h005, 11'h009,
                                11'h00B, 11'h021};
    sdc_host u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));
    sdc_divider_chain u_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .VCO_TICK_O(tick), .HS_CLK_O(hs_clk), .CLK_O(out_clk));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        u_host.rd(a, q);
        chk($sformatf("reg %h", a), exp, q);
    endtask
    task automatic ticks(input int cycles, output int n);
        n = 0;
        repeat (cycles)
        begin
            @(negedge clk);
            if (tick === 1'b1) n++;
        end
        @(posedge clk);
    endtask
    task automatic span(input logic use_hs, output int per, output int hi);
        int n;
        logic s;
        logic p;
        logic td1;
        logic td2;
        n = 0;
        per = 0;
        hi = 0;
        p = 1'b1;
        td1 = 1'b0;
        td2 = 1'b0;
        while (n < 3)
        begin
            @(negedge clk);
            s = use_hs ? hs_clk : out_clk;
            // clock edges trail the tick that causes them by two cycles
            if (s === 1'b1 && p === 1'b0) n++;
            if (n == 2 && td2 === 1'b1) per++;
            if (n == 2 && td2 === 1'b1 && s === 1'b1) hi++;
            p = s;
            td2 = td1;
            td1 = tick;
        end
        @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_fail++;
            give_verdict;
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk(SDC_OFS_FB_INT, 32'h3C);
        rchk(SDC_OFS_HS, 32'h44);
        rchk(SDC_OFS_ACT_FRAC, 32'h0);
        ticks(2048, per);
        chk("ticks", 32'h3C, 32'(per));
        $display("reset test done");
        u_host.wr(SDC_OFS_FB_FRAC, 32'h80000000);
        u_host.wr(SDC_OFS_FB_INT, 32'h64);
        rchk(SDC_OFS_CTRL, 32'h2);
        rchk(SDC_OFS_ACT_INT, 32'h3C);
        u_host.wr(SDC_OFS_HS, 32'hFFFFF805);
        rchk(SDC_OFS_HS, 32'h5);
        u_host.wr(SDC_OFS_LS, 32'hF);
        rchk(SDC_OFS_LS, 32'h7);
        u_host.wr(8'h40, 32'h1);
        rchk(8'h40, 32'h0);
        u_host.wr(SDC_OFS_CTRL, 32'h1);
        rchk(SDC_OFS_CTRL, 32'h0);
        u_host.wr(SDC_OFS_ACT_INT, 32'h1);
        rchk(SDC_OFS_ACT_INT, 32'h64);
        u_host.rd(SDC_OFS_ACT_DIV, q);
        chk("active set", 32'h70005, q & 32'hFFFFFF);
        ticks(4096, per);
        chk("ticks", 32'hC9, 32'(per));
        $display("apply test done");
        for (int i = 0; i < 8; i++)
        begin
            u_host.prog_set(11'h7D0, 32'h0, hs_tab[i], 3'(i));
            span(1'b1, per, hi);
            chk("hs period", 32'(2 * hs_tab[i]), 32'(per));
            chk("hs high", 32'(hs_tab[i]), 32'(hi));
            span(1'b0, per, hi);
            chk("out period", 32'(2 * hs_tab[i]) << (i > 5 ? 5 : i), 32'(per));
        end
        $display("divider test done");
        give_verdict;
    end
endmodule
